// ### stc_consts.vh
// constants for the switch tuning configuration register bank
`ifndef STC_CONSTS_VH
`define STC_CONSTS_VH
`define STC_OFS_CTLA 8'h00A8
`define STC_OFS_CTLB 8'h00AC
`define STC_OFS_TMR 8'h00B0
`define STC_OFS_MODE 8'h00B4
`define STC_RST_CTLA 32'h0400_1060
`define STC_RST_CTLB 32'h0400_0800
`define STC_RST_RPL 12'h000
`define STC_RST_ACK 14'h0000
`define STC_RST_THR 2'h1
`define STC_RST_PMC 6'h00
`define STC_RPL_MSB 11
`define STC_RPL_EN 12
`define STC_CAPD_LSB 13
`define STC_CAPD_MSB 15
`define STC_ACK_LSB 16
`define STC_ACK_MSB 29
`define STC_ACK_EN 30
`define STC_VGA 31
`define STC_SF 0
`define STC_THR_LSB 1
`define STC_THR_MSB 2
`define STC_ARB 3
`define STC_CRD 4
`define STC_ORD_PORT 5
`define STC_ORD_TAG 6
`define STC_PMC_LSB 8
`define STC_PMC_MSB 13
`define STC_RXP 14
`define STC_CPP 15
`define STC_CRD_ONE 2'h1
`define STC_CRD_TWO 2'h2
`define STC_THR_W 2
`endif

// ### stc_fwd_point.v
// cut-through start point from packet length and threshold code
`include "stc_consts.vh"
module stc_fwd_point (
  // packet info
  input wire [11:0] pkt_len,
  input wire slow_to_fast,
  input wire [`STC_THR_W-1:0] thr_code,
  // result
  output wire [11:0] start_cycle
);
  wire [11:0] mid;
  wire [11:0] adv;
  assign mid = {1'b0, pkt_len[11:1]};
  assign adv = slow_to_fast ? {10'h000, thr_code} : 12'h000;
  assign start_cycle = (mid > adv) ? (mid - adv) : 12'h000;
endmodule

// ### stc_link_model.sv
// far-side traffic model driving arbiter requests and credit
module stc_link_model (
  // clock and reset
  input wire clock,
  input wire resetn,
  // credit starvation control
  input wire starve,
  // arbiter side
  output logic [3:0] arb_req,
  output logic [3:0] arb_credit_ok,
  output logic arb_advance
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] q;
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      q <= 8'h5A;
      {arb_req, arb_credit_ok, arb_advance} <= '0;
    end else begin
      q <= {q[6:0], q[7] ^ q[5] ^ q[4] ^ q[3]};
      arb_req <= q[3:0];
      arb_credit_ok <= starve ? 4'h0 : q[7:4];
      arb_advance <= q[1];
    end
  end
endmodule

// ### stc_regs.v
// switch tuning configuration registers with their control outputs
`include "stc_consts.vh"
// Notes on behaviour
// - 12-bit user replay value in bits 11:0, reset zero.
// - replay enable bit 12 selects user value over built-in limit.
// - 14-bit ack latency in 29:16, enable in bit 30, reset zero.
// - defaults replaceable by side-port writes or eeprom autoload.
// - bit 31 vga enable, read-only, resets one, eeprom only alters.
// - mode bit 0 set means store-and-forward, clear cut-through.
// - threshold applies when forwarding slow port to fast port.
// - code 0 midpoint, 1..3 start that many cycles earlier; reset 01.
// - arbitration bit set holds current grant while request pending.
// - bit clear moves to requesting port with enough credit.
// - credit bit set releases one credit per update, else two.
// - bit 5 enforces ordering across egress ports.
// - bit 6 enforces ordering among completions of different tags.
module stc_regs (
  // clock and reset
  input wire clock,
  input wire resetn,
  // configuration access from host
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [7:0] cfg_addr,
  input wire [3:0] cfg_be,
  input wire [31:0] cfg_wdata,
  output reg [31:0] cfg_rdata,
  // side port default override
  input wire smb_wr,
  input wire [7:0] smb_addr,
  input wire [31:0] smb_wdata,
  // eeprom autoload
  input wire ee_wr,
  input wire [7:0] ee_addr,
  input wire [31:0] ee_wdata,
  // built-in limits
  input wire [11:0] def_replay_limit,
  input wire [13:0] def_ack_limit,
  // forwarding datapath info
  input wire [11:0] pkt_len,
  input wire slow_to_fast,
  // arbiter status
  input wire [3:0] arb_req,
  input wire [3:0] arb_credit_ok,
  input wire arb_advance,
  // tuning outputs
  output wire [11:0] replay_limit,
  output wire [13:0] ack_limit,
  output wire store_forward,
  output wire [11:0] fwd_start_cycle,
  output reg [3:0] arb_grant,
  output wire [1:0] credit_per_update,
  output wire order_cross_port,
  output wire order_cpl_tag,
  output wire vga_enable
);
  reg [31:0] ctla_r;
  reg [31:0] ctlb_r;
  reg [11:0] rpl_r;
  reg rpl_en_r;
  reg [2:0] capd_r;
  reg [13:0] ack_r;
  reg ack_en_r;
  reg vga_r;
  reg sf_r;
  reg [1:0] thr_r;
  reg arb_r;
  reg crd_r;
  reg ordp_r;
  reg ordt_r;
  reg [5:0] pmc_r;
  reg rxp_r;
  reg cpp_r;
  reg [3:0] arb_grant_nxt;

  function [31:0] bemerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    begin
      bemerge = {be[3] ? nw[31:24] : old[31:24], be[2] ? nw[23:16] : old[23:16],
                 be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  // next port after cur, rotating, among eligible
  function [3:0] rr_pick;
    input [3:0] cur;
    input [3:0] elig;
    reg [7:0] dbl;
    reg [3:0] res;
    integer i;
    integer off;
    integer j;
    begin
      dbl = {elig, elig};
      res = 4'h0;
      off = (cur[1] ? 1 : 0) + (cur[2] ? 2 : 0) + (cur[3] ? 3 : 0);
      for (i = 3; i >= 0; i = i - 1) begin
        j = (i + 1 + off) % 4;
        // nearest eligible port after the current one wins
        if (dbl[i + 1 + off]) begin
          res = 4'h0;
          res[j] = 1'b1;
        end
      end
      rr_pick = res;
    end
  endfunction

  // write source: eeprom first, then side port, then host
  wire ee_hit_tmr = ee_wr && (ee_addr == `STC_OFS_TMR);
  wire ee_hit_mode = ee_wr && (ee_addr == `STC_OFS_MODE);
  wire sm_hit_tmr = smb_wr && (smb_addr == `STC_OFS_TMR);
  wire sm_hit_mode = smb_wr && (smb_addr == `STC_OFS_MODE);
  wire h_tmr = cfg_wr && (cfg_addr == `STC_OFS_TMR);
  wire h_mode = cfg_wr && (cfg_addr == `STC_OFS_MODE);
  wire [31:0] tmr_cur = {vga_r, ack_en_r, ack_r, capd_r, rpl_en_r, rpl_r};
  wire [31:0] mode_cur = {16'h0000, cpp_r, rxp_r, pmc_r, 1'b0, ordt_r, ordp_r,
                          crd_r, arb_r, thr_r, sf_r};
  wire [31:0] tmr_w = ee_hit_tmr ? ee_wdata : sm_hit_tmr ? smb_wdata
                      : bemerge(tmr_cur, cfg_wdata, cfg_be);
  wire [31:0] mode_w = ee_hit_mode ? ee_wdata : sm_hit_mode ? smb_wdata
                       : bemerge(mode_cur, cfg_wdata, cfg_be);
  wire tmr_we = ee_hit_tmr | sm_hit_tmr | h_tmr;
  wire mode_we = ee_hit_mode | sm_hit_mode | h_mode;
  wire aux_we = ee_hit_tmr | sm_hit_tmr;
  wire maux_we = ee_hit_mode | sm_hit_mode;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctla_r <= `STC_RST_CTLA;
      ctlb_r <= `STC_RST_CTLB;
      rpl_r <= `STC_RST_RPL;
      rpl_en_r <= 1'b0;
      capd_r <= 3'h0;
      ack_r <= `STC_RST_ACK;
      ack_en_r <= 1'b0;
      vga_r <= 1'b1;
      sf_r <= 1'b0;
      thr_r <= `STC_RST_THR;
      arb_r <= 1'b0;
      crd_r <= 1'b0;
      ordp_r <= 1'b0;
      ordt_r <= 1'b0;
      pmc_r <= `STC_RST_PMC;
      rxp_r <= 1'b0;
      cpp_r <= 1'b0;
    end else begin
      if (cfg_wr && cfg_addr == `STC_OFS_CTLA)
        ctla_r <= bemerge(ctla_r, cfg_wdata, cfg_be);
      if (cfg_wr && cfg_addr == `STC_OFS_CTLB)
        ctlb_r <= bemerge(ctlb_r, cfg_wdata, cfg_be);
      if (tmr_we) begin
        rpl_r <= tmr_w[`STC_RPL_MSB:0];
        rpl_en_r <= tmr_w[`STC_RPL_EN];
        ack_r <= tmr_w[`STC_ACK_MSB:`STC_ACK_LSB];
        ack_en_r <= tmr_w[`STC_ACK_EN];
      end
      if (aux_we)
        capd_r <= tmr_w[`STC_CAPD_MSB:`STC_CAPD_LSB];
      if (ee_hit_tmr)
        vga_r <= ee_wdata[`STC_VGA];
      if (mode_we) begin
        sf_r <= mode_w[`STC_SF];
        thr_r <= mode_w[`STC_THR_MSB:`STC_THR_LSB];
        arb_r <= mode_w[`STC_ARB];
        crd_r <= mode_w[`STC_CRD];
        ordp_r <= mode_w[`STC_ORD_PORT];
        ordt_r <= mode_w[`STC_ORD_TAG];
        pmc_r <= mode_w[`STC_PMC_MSB:`STC_PMC_LSB];
      end
      if (maux_we) begin
        rxp_r <= mode_w[`STC_RXP];
        cpp_r <= mode_w[`STC_CPP];
      end
    end
  end

  always @* begin
    cfg_rdata = 32'h0000_0000;
    if (cfg_rd) begin
      case (cfg_addr)
        `STC_OFS_CTLA: cfg_rdata = ctla_r;
        `STC_OFS_CTLB: cfg_rdata = ctlb_r;
        `STC_OFS_TMR: cfg_rdata = tmr_cur;
        `STC_OFS_MODE: cfg_rdata = mode_cur;
        default: cfg_rdata = 32'h0000_0000;
      endcase
    end
  end

  assign replay_limit = rpl_en_r ? rpl_r : def_replay_limit;
  assign ack_limit = ack_en_r ? ack_r : def_ack_limit;
  assign store_forward = sf_r;
  assign credit_per_update = crd_r ? `STC_CRD_ONE : `STC_CRD_TWO;
  assign order_cross_port = ordp_r;
  assign order_cpl_tag = ordt_r;
  assign vga_enable = vga_r;

  stc_fwd_point u_fwd (
    .pkt_len(pkt_len),
    .slow_to_fast(slow_to_fast),
    .thr_code(thr_r),
    .start_cycle(fwd_start_cycle)
  );

  always @* begin
    arb_grant_nxt = arb_grant;
    if (arb_advance) begin
      // hold grant while its request pends
      if (arb_r && |(arb_grant & arb_req))
        arb_grant_nxt = arb_grant;
      else if (|(arb_req & arb_credit_ok))
        arb_grant_nxt = rr_pick(arb_grant, arb_req & arb_credit_ok);
      else
        arb_grant_nxt = arb_grant;
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn)
      arb_grant <= 4'h1;
    else
      arb_grant <= arb_grant_nxt;
  end
endmodule

// ### stc_regs_props.sv
// assertions on the tuning register bank ports
module stc_regs_props (
  // watched ports
  input wire clock, resetn, cfg_rd, ee_wr, slow_to_fast, arb_advance,
  input wire store_forward, order_cross_port, order_cpl_tag, vga_enable,
  input wire [7:0] cfg_addr, ee_addr,
  input wire [31:0] cfg_rdata,
  input wire [11:0] def_replay_limit, pkt_len, replay_limit, fwd_start_cycle,
  input wire [13:0] def_ack_limit, ack_limit,
  input wire [3:0] arb_req, arb_credit_ok, arb_grant,
  input wire [1:0] credit_per_update
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire rd0 = cfg_rd && cfg_addr == 8'hB0;
  wire rd4 = cfg_rd && cfg_addr == 8'hB4;
  wire [10:0] mid = pkt_len[11:1];
  wire [1:0] thr = cfg_rdata[2:1];
  sequence move_s;
    arb_advance && |(arb_req & arb_credit_ok) && !(|(arb_grant & arb_req));
  endsequence
  replay_mux_a: assert property (rd0 |-> replay_limit ==
    (cfg_rdata[12] ? cfg_rdata[11:0] : def_replay_limit)) else $error("replay limit");
  ack_mux_a: assert property (rd0 |-> ack_limit ==
    (cfg_rdata[30] ? cfg_rdata[29:16] : def_ack_limit)) else $error("ack limit");
  mode_bits_a: assert property (rd4 |-> store_forward == cfg_rdata[0] &&
    {order_cpl_tag, order_cross_port} == cfg_rdata[6:5] &&
    credit_per_update == (cfg_rdata[4] ? 2'h1 : 2'h2)) else $error("mode outputs");
  fwd_point_a: assert property (rd4 |-> fwd_start_cycle == (!slow_to_fast ? {1'b0, mid} :
    mid > thr ? {1'b0, mid} - thr : 12'h000)) else $error("start point");
  vga_keep_a: assert property (!(ee_wr && ee_addr == 8'hB0) |=>
    $stable(vga_enable)) else $error("vga changed");
  grant_hold_a: assert property (!arb_advance || !(|(arb_req & arb_credit_ok)) |=>
    $stable(arb_grant)) else $error("grant moved");
  grant_move_a: assert property (move_s |=>
    |(arb_grant & $past(arb_req) & $past(arb_credit_ok))) else $error("grant stuck");
  grant_onehot_a: assert property ($onehot(arb_grant)) else $error("grant not one-hot");
endmodule
bind stc_regs stc_regs_props u_props (.*);

// ### tb_stc_regs.sv
// self-checking bench for the tuning register bank
module tb_stc_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, resetn, cfg_wr, cfg_rd, smb_wr, ee_wr, slow_to_fast, starve;
  logic [7:0] cfg_addr, smb_addr, ee_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, smb_wdata, ee_wdata, d, e, sa, sb;
  logic [11:0] def_replay_limit, pkt_len;
  logic [13:0] def_ack_limit;
  logic [15:0] s = 16'hDBEC;
  wire [3:0] arb_req, arb_credit_ok, arb_grant;
  wire arb_advance, store_forward, order_cross_port, order_cpl_tag, vga_enable;
  wire [1:0] credit_per_update;
  wire [11:0] replay_limit, fwd_start_cycle;
  wire [13:0] ack_limit;
  wire [31:0] cfg_rdata;
  int bad_count, n_compared, cyc;
  logic hold_mode = 1'b0;
  logic [3:0] g_q = 4'h0, r_q = 4'h0;
  logic a_q = 1'b0;
  stc_regs dut (.*);
  stc_link_model peer (.*);
  function logic [31:0] r32();
    repeat (2) begin
      s = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
      r32 = {r32[15:0], s};
    end
  endfunction
  function logic [31:0] mg(logic [31:0] o, n, logic [3:0] b);
    for (int i = 0; i < 4; i++) mg[8*i+:8] = b[i] ? n[8*i+:8] : o[8*i+:8];
  endfunction
  function logic [11:0] fx(logic [11:0] n, logic f, logic [1:0] t);
    fx = !f ? n >> 1 : (n >> 1) > t ? (n >> 1) - t : 12'h000;
  endfunction
  task finish_test();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(string n, logic [31:0] x, logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", n, x, g);
    end
  endtask
  task wr(logic [7:0] a, logic [3:0] b, logic [31:0] v);
    cfg_addr <= a;
    cfg_be <= b;
    cfg_wdata <= v;
    cfg_wr <= 1;
    @(posedge clock);
    cfg_wr <= 0;
    @(posedge clock);
  endtask
  task rd(logic [7:0] a, logic [31:0] x);
    cfg_addr <= a;
    cfg_rd <= 1;
    @(negedge clock);
    chk("cfg_rdata", x, cfg_rdata);
    @(posedge clock);
    cfg_rd <= 0;
    @(posedge clock);
  endtask
  task sw(logic p, logic [31:0] v);
    if (p) {ee_wr, ee_addr, ee_wdata} <= {1'b1, 8'hB0, v};
    else {smb_wr, smb_addr, smb_wdata} <= {1'b1, 8'hB0, v};
    @(posedge clock);
    {ee_wr, smb_wr} <= 2'h0;
    @(posedge clock);
  endtask
  initial begin
    clock = 0;
    forever #10 clock = ~clock;
  end
  always @(negedge clock) begin
    if (hold_mode && resetn && a_q && |(g_q & r_q)) chk("grant hold", g_q, arb_grant);
    g_q <= arb_grant;
    r_q <= arb_req;
    a_q <= arb_advance;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    {resetn, cfg_wr, cfg_rd, smb_wr, ee_wr, starve, slow_to_fast, cfg_be} = '0;
    {cfg_addr, smb_addr, ee_addr, cfg_wdata, smb_wdata, ee_wdata} = '0;
    {def_replay_limit, def_ack_limit, pkt_len} = {12'h5A5, 14'h1234, 12'h041};
    sa = 32'h0400_1060;
    sb = 32'h0400_0800;
    repeat (12) @(posedge clock);
    resetn <= 1;
    @(posedge clock);
    chk("grant", 32'h1, arb_grant);
    rd(8'hA8, sa);
    rd(8'hAC, sb);
    rd(8'hB0, 32'h8000_0000);
    rd(8'hB4, 32'h0000_0002);
    rd(8'hB8, 32'h0000_0000);
    chk("replay", def_replay_limit, replay_limit);
    chk("credit", 2, credit_per_update);
    $display("reset test done");
    wr(8'hB0, 4'hF, 32'hFFFF_FFFF);
    rd(8'hB0, 32'hFFFF_1FFF);
    chk("replay", 12'hFFF, replay_limit);
    chk("ack", 14'h3FFF, ack_limit);
    $display("limit test done");
    for (int i = 0; i < 8; i++) begin
      d = r32();
      e = r32();
      wr(8'hA8, e[3:0], d);
      sa = mg(sa, d, e[3:0]);
      rd(8'hA8, sa);
      wr(8'hAC, e[7:4], ~d);
      sb = mg(sb, ~d, e[7:4]);
      rd(8'hAC, sb);
      d[2:1] = i[1:0];
      wr(8'hB4, 4'hF, d);
      pkt_len <= e[27:16];
      slow_to_fast <= e[8];
      rd(8'hB4, d & 32'h0000_3F7F);
      chk("fwd", fx(e[27:16], e[8], i[1:0]), fwd_start_cycle);
      chk("credit", d[4] ? 1 : 2, credit_per_update);
      chk("store_fwd", d[0], store_forward);
      chk("order_port", d[5], order_cross_port);
      chk("order_tag", d[6], order_cpl_tag);
    end
    $display("random test done");
    d = r32() & 32'h7FFF_FFFF;
    sw(1, d);
    rd(8'hB0, d);
    e = r32();
    sw(0, e);
    rd(8'hB0, {1'b0, e[30:0]});
    wr(8'hB0, 4'hF, 32'hFFFF_FFFF);
    rd(8'hB0, {1'b0, 15'h7FFF, e[15:13], 13'h1FFF});
    chk("vga", 0, vga_enable);
    $display("side port test done");
    wr(8'hB4, 4'h1, 32'h0000_0008);
    hold_mode <= 1'b1;
    repeat (150) @(posedge clock);
    starve <= 1;
    repeat (50) @(posedge clock);
    starve <= 0;
    hold_mode <= 1'b0;
    wr(8'hB4, 4'h1, 32'h0000_0000);
    repeat (150) @(posedge clock);
    $display("arbiter test done");
    finish_test();
  end
endmodule
